// ### shared/printer_port_defs.svh
// Offsets, field positions and reset values of the printer port block.
// Included by the design modules; the package does not include it.
`ifndef PRINTER_PORT_DEFS_SVH
`define PRINTER_PORT_DEFS_SVH

// ----------------------------------------
// Port addresses
// ----------------------------------------
`define OFS_SENSOR_STATUS_A   8'h50
`define OFS_SWITCH_STATUS_B   8'h51
`define OFS_FRONT_INDICATOR   8'h54
`define OFS_WHEEL_MOTOR       8'h58
`define OFS_HEAD_TRAVEL       8'h59
`define OFS_SHEET_FEED        8'h5A
`define OFS_INK_BAND          8'h5B
`define OFS_STRIKE_COIL       8'h5C
`define OFS_SERVICE_READOUT   8'h5F

// ----------------------------------------
// Decoder fields
// ----------------------------------------
`define GROUP_CODE            3'h5
`define STATUS_SUB_CODE       2'h0
`define PORT_A_SEL            2'h0
`define PORT_B_SEL            2'h1

// ----------------------------------------
// Motor and coil latch fields
// ----------------------------------------
`define MOT_PHASE_LSB         0
`define MOT_HOLD_BIT          4
`define MOT_SEQ_MODE_BIT      5
`define MOT_DIR_BIT           6
`define COIL_FIRE_BIT         0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LATCH_RESET           8'h00
`define PHASE_RESET           4'h0

`endif

// ### shared/printer_port_pkg.sv
// Types shared by the printer port block and its motor channels.
package printer_port_pkg;

    // Half-step positions: even codes are wave states, odd are two-phase
    typedef enum logic [2:0] {
        HS_0 = 3'b000,
        HS_1 = 3'b001,
        HS_2 = 3'b010,
        HS_3 = 3'b011,
        HS_4 = 3'b100,
        HS_5 = 3'b101,
        HS_6 = 3'b110,
        HS_7 = 3'b111
    } half_step_t;

    typedef enum logic [1:0] {
        MOTOR_WHEEL = 2'b00,
        MOTOR_HEAD  = 2'b01,
        MOTOR_SHEET = 2'b10,
        MOTOR_BAND  = 2'b11
    } motor_sel_t;

endpackage

// ### src/motor_channel.sv
// One stepper channel: half-step state generator, hold, and chopper drive.
// Assumes current comparators arrive synchronous to clock, one per winding.
`timescale 1ns/1ps
`default_nettype none
`include "printer_port_defs.svh"

module motor_channel
    import printer_port_pkg::*;
#(
    parameter int PHASES = 4
) (
    input  wire logic              clock,
    input  wire logic              srst,
    input  wire logic [7:0]        latch,
    input  wire logic              step_pulse,
    input  wire logic              drive_en,
    input  wire logic [PHASES-1:0] cur_at_target,
    input  wire logic [PHASES-1:0] cur_below_low,
    output logic      [PHASES-1:0] phase_q,
    output logic                   hold_q,
    output logic      [PHASES-1:0] high_sw_q,
    output logic      [PHASES-1:0] low_sw_q
);

    half_step_t        state_q;
    half_step_t        state_d;
    logic              step_prev_q;
    logic [PHASES-1:0] table_phase;
    logic [PHASES-1:0] phase_d;
    wire  logic        hold_bit = latch[`MOT_HOLD_BIT];
    wire  logic        seq_mode = latch[`MOT_SEQ_MODE_BIT];
    wire  logic        step_edge = step_pulse & ~step_prev_q;

    // ----------------------------------------
    // State generator
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        if (seq_mode && step_edge && !hold_bit) begin
            if (latch[`MOT_DIR_BIT]) begin
                state_d = half_step_t'(state_q - 3'h1);
            end else begin
                state_d = half_step_t'(state_q + 3'h1);
            end
        end
    end

    // Wave and two-phase patterns alternate, giving half steps
    always_comb begin
        case (state_q)
            HS_0:    table_phase = 4'h1;
            HS_1:    table_phase = 4'h3;
            HS_2:    table_phase = 4'h2;
            HS_3:    table_phase = 4'h6;
            HS_4:    table_phase = 4'h4;
            HS_5:    table_phase = 4'hC;
            HS_6:    table_phase = 4'h8;
            HS_7:    table_phase = 4'h9;
            default: table_phase = 4'h0;
        endcase
    end

    // Hold freezes the applied pattern whatever the latch says
    assign phase_d = hold_bit ? phase_q :
                     seq_mode ? table_phase :
                     latch[`MOT_PHASE_LSB +: PHASES];

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q     <= HS_0;
            step_prev_q <= 1'b0;
            phase_q     <= `PHASE_RESET;
            hold_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            step_prev_q <= step_pulse;
            phase_q     <= phase_d;
            hold_q      <= hold_bit;
        end
    end

    // ----------------------------------------
    // Chopper, one per winding
    // ----------------------------------------
    genvar w;
    generate
        for (w = 0; w < PHASES; w++) begin : g_wind
            wire logic on = phase_q[w] & drive_en;
            always_ff @(posedge clock) begin
                if (srst) begin
                    high_sw_q[w] <= 1'b0;
                    low_sw_q[w]  <= 1'b0;
                end else if (!on) begin
                    // Both off: winding dumps back into the supply
                    high_sw_q[w] <= 1'b0;
                    low_sw_q[w]  <= 1'b0;
                end else begin
                    low_sw_q[w] <= 1'b1;
                    if (!low_sw_q[w] || cur_below_low[w]) begin
                        high_sw_q[w] <= 1'b1;
                    end else if (cur_at_target[w]) begin
                        high_sw_q[w] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

endmodule // motor_channel

`default_nettype wire

// ### src/printer_port_ctrl.sv
// Printer port block: host I/O decode, status ports, output latches,
// motor fault gating and four stepper channels.
// Assumes host I/O strobes are synchronous to clock and held for >= 1 cycle.
//
// How it works
// - Reads at 50h/51h give status A/B
// - Write-only latches at 54,58-5C,5F
// - Group selected when bits 6..4 are 101
// - Status ports need address bits 3,2 low
// - Bits 1,0 low select status A
// - Read needs rd and request low together
// - Status B carries panel switch states
// - Status B bit 7 shows motor power
// - Write to 58h latches wheel byte
// - Latch bits 0..3 drive motor phases
// - Hold bit freezes motor position
// - Bad phase code lights fault, stops drive
// - Half steps: wave and two-phase alternate
// - State generator advances per step pulse
// - Chopper regulates winding current between thresholds
// - Drive pulse end switches both off
`timescale 1ns/1ps
`default_nettype none
`include "printer_port_defs.svh"

module printer_port_ctrl
    import printer_port_pkg::*;
#(
    parameter int MOTORS = 4,
    parameter int PHASES = 4
) (
    input  wire logic                     clock,
    input  wire logic                     srst,
    // Host I/O bus
    input  wire logic [7:0]               addr,
    input  wire logic [7:0]               wdata,
    input  wire logic                     rd_n,
    input  wire logic                     wr_n,
    input  wire logic                     io_request_n,
    output logic      [7:0]               rdata,
    output logic                          rdata_oe,
    // Sensors
    input  wire logic                     right_margin,
    input  wire logic                     left_margin,
    input  wire logic                     ribbon_out,
    input  wire logic                     paper_out,
    input  wire logic                     cover_open,
    // Panel switches and motor supply status
    input  wire logic                     top_of_page_sw,
    input  wire logic                     paper_load_sw,
    input  wire logic                     line_feed_down_sw,
    input  wire logic                     line_feed_up_sw,
    input  wire logic                     roll_down_sw,
    input  wire logic                     roll_up_sw,
    input  wire logic                     select_sw,
    input  wire logic                     motor_power_ok,
    // Motor side, motor m uses bit m of step_pulse and hold_out, bits [m*PHASES +: PHASES] of the rest
    input  wire logic [MOTORS-1:0]        step_pulse,
    input  wire logic [MOTORS*PHASES-1:0] cur_at_target,
    input  wire logic [MOTORS*PHASES-1:0] cur_below_low,
    output logic      [MOTORS*PHASES-1:0] phase_out,
    output logic      [MOTORS-1:0]        hold_out,
    output logic      [MOTORS*PHASES-1:0] high_sw,
    output logic      [MOTORS*PHASES-1:0] low_sw,
    // Coil and panel
    output logic                          hammer_coil,
    output logic      [7:0]               front_indicator_latch,
    output logic      [7:0]               service_readout,
    output logic                          board_fault_led
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire logic addr_bit0 = addr[0];
    wire logic addr_bit1 = addr[1];
    wire logic addr_bit2 = addr[2];
    wire logic addr_bit3 = addr[3];
    wire logic addr_bit4 = addr[4];
    wire logic addr_bit5 = addr[5];
    wire logic addr_bit6 = addr[6];

    // Only bits 6..0 are decoded, so the map repeats above 80h
    wire logic group_sel =
        ({addr_bit6, addr_bit5, addr_bit4} == `GROUP_CODE);
    wire logic status_sel = group_sel &&
        ({addr_bit3, addr_bit2} == `STATUS_SUB_CODE);
    wire logic port_a_sel = status_sel &&
        ({addr_bit1, addr_bit0} == `PORT_A_SEL);
    wire logic port_b_sel = status_sel &&
        ({addr_bit1, addr_bit0} == `PORT_B_SEL);

    wire logic io_read  = !io_request_n && !rd_n;
    wire logic io_write = !io_request_n && !wr_n;

    wire logic [6:0] low_addr = addr[6:0];
    // Offsets are full bytes; bit 7 is dropped on purpose to match the decoder
    wire logic wr_front   = io_write && (low_addr == 7'(`OFS_FRONT_INDICATOR));
    wire logic wr_wheel   = io_write && (low_addr == 7'(`OFS_WHEEL_MOTOR));
    wire logic wr_head    = io_write && (low_addr == 7'(`OFS_HEAD_TRAVEL));
    wire logic wr_sheet   = io_write && (low_addr == 7'(`OFS_SHEET_FEED));
    wire logic wr_band    = io_write && (low_addr == 7'(`OFS_INK_BAND));
    wire logic wr_strike  = io_write && (low_addr == 7'(`OFS_STRIKE_COIL));
    wire logic wr_service = io_write && (low_addr == 7'(`OFS_SERVICE_READOUT));

    // ----------------------------------------
    // Status ports
    // ----------------------------------------
    wire logic [7:0] status_a = {3'h0, cover_open, paper_out,
                                 ribbon_out, left_margin, right_margin};
    wire logic [7:0] status_b = {motor_power_ok,
                                 select_sw, roll_up_sw, roll_down_sw,
                                 line_feed_up_sw, line_feed_down_sw,
                                 paper_load_sw, top_of_page_sw};

    // Bus is released for any address other than the two status ports
    wire logic       read_hit = io_read && (port_a_sel || port_b_sel);
    wire logic [7:0] read_mux = port_a_sel ? status_a : status_b;

    always_ff @(posedge clock) begin
        if (srst) begin
            rdata    <= 8'h00;
            rdata_oe <= 1'b0;
        end else begin
            rdata    <= read_hit ? read_mux : 8'h00;
            rdata_oe <= read_hit;
        end
    end

    // ----------------------------------------
    // Output latches
    // ----------------------------------------
    logic [7:0] front_indicator_latch_q;
    logic [7:0] wheel_motor_latch_q;
    logic [7:0] head_travel_latch_q;
    logic [7:0] sheet_feed_latch_q;
    logic [7:0] ink_band_latch_q;
    logic [7:0] strike_coil_latch_q;
    logic [7:0] service_readout_latch_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            front_indicator_latch_q <= `LATCH_RESET;
            wheel_motor_latch_q     <= `LATCH_RESET;
            head_travel_latch_q     <= `LATCH_RESET;
            sheet_feed_latch_q      <= `LATCH_RESET;
            ink_band_latch_q        <= `LATCH_RESET;
            strike_coil_latch_q     <= `LATCH_RESET;
            service_readout_latch_q <= `LATCH_RESET;
        end else begin
            if (wr_front) begin
                front_indicator_latch_q <= wdata;
            end
            if (wr_wheel) begin
                wheel_motor_latch_q <= wdata;
            end
            if (wr_head) begin
                head_travel_latch_q <= wdata;
            end
            if (wr_sheet) begin
                sheet_feed_latch_q <= wdata;
            end
            if (wr_band) begin
                ink_band_latch_q <= wdata;
            end
            if (wr_strike) begin
                strike_coil_latch_q <= wdata;
            end
            if (wr_service) begin
                service_readout_latch_q <= wdata;
            end
        end
    end

    // Indexed view of the motor latches, ordered as motor_sel_t
    logic [7:0] motor_latch [MOTORS];
    assign motor_latch[MOTOR_WHEEL] = wheel_motor_latch_q;
    assign motor_latch[MOTOR_HEAD]  = head_travel_latch_q;
    assign motor_latch[MOTOR_SHEET] = sheet_feed_latch_q;
    assign motor_latch[MOTOR_BAND]  = ink_band_latch_q;

    // ----------------------------------------
    // Fault decode
    // ----------------------------------------
    // Opposite poles of one winding energised together is a short
    // through the bridge, so such a code is treated as a fault.
    logic [MOTORS-1:0] code_fault;

    genvar m;
    generate
        for (m = 0; m < MOTORS; m++) begin : g_fault
            wire logic [3:0] ph = motor_latch[m][`MOT_PHASE_LSB +: 4];
            assign code_fault[m] = (ph[0] & ph[2]) | (ph[1] & ph[3]);
        end
    endgenerate

    wire logic any_fault = |code_fault;
    // Drive is also held off while the motor supply is absent
    wire logic drive_en  = !any_fault && motor_power_ok;

    logic drive_en_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            board_fault_led <= 1'b0;
            drive_en_q      <= 1'b0;
        end else begin
            board_fault_led <= any_fault;
            drive_en_q      <= drive_en;
        end
    end

    // ----------------------------------------
    // Coil and panel outputs
    // ----------------------------------------
    // Coil timing is software's job; it is only blocked during a fault
    wire logic coil_d = strike_coil_latch_q[`COIL_FIRE_BIT] && !any_fault;

    always_ff @(posedge clock) begin
        if (srst) begin
            hammer_coil     <= 1'b0;
            front_indicator_latch      <= `LATCH_RESET;
            service_readout <= `LATCH_RESET;
        end else begin
            hammer_coil     <= coil_d;
            front_indicator_latch      <= front_indicator_latch_q;
            service_readout <= service_readout_latch_q;
        end
    end

    // ----------------------------------------
    // Stepper channels
    // ----------------------------------------
    // Step pulses come from the host timer channels
    generate
        for (m = 0; m < MOTORS; m++) begin : g_motor
            motor_channel #(
                .PHASES (PHASES)
            ) u_channel (
                .clock         (clock),
                .srst          (srst),
                .latch         (motor_latch[m]),
                .step_pulse    (step_pulse[m]),
                .drive_en      (drive_en_q),
                .cur_at_target (cur_at_target[m*PHASES +: PHASES]),
                .cur_below_low (cur_below_low[m*PHASES +: PHASES]),
                .phase_q       (phase_out[m*PHASES +: PHASES]),
                .hold_q        (hold_out[m]),
                .high_sw_q     (high_sw[m*PHASES +: PHASES]),
                .low_sw_q      (low_sw[m*PHASES +: PHASES])
            );
        end
    endgenerate

endmodule // printer_port_ctrl

`default_nettype wire

// ### testbench/printer_port_ctrl_assertions.sv
// Checker for the printer port block: bus answers, latches, fault and drive.
// Bound to every printer_port_ctrl; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module printer_port_ctrl_assertions #(
    parameter int MOTORS = 4,
    parameter int PHASES = 4
) (
    input wire logic                     clock,
    input wire logic                     srst,
    input wire logic [7:0]               addr,
    input wire logic [7:0]               wdata,
    input wire logic                     rd_n,
    input wire logic                     wr_n,
    input wire logic                     io_request_n,
    input wire logic [7:0]               rdata,
    input wire logic                     rdata_oe,
    input wire logic                     right_margin,
    input wire logic                     left_margin,
    input wire logic                     ribbon_out,
    input wire logic                     paper_out,
    input wire logic                     cover_open,
    input wire logic                     motor_power_ok,
    input wire logic [MOTORS*PHASES-1:0] cur_at_target,
    input wire logic [MOTORS*PHASES-1:0] cur_below_low,
    input wire logic [MOTORS*PHASES-1:0] phase_out,
    input wire logic [MOTORS-1:0]        hold_out,
    input wire logic [MOTORS*PHASES-1:0] high_sw,
    input wire logic [MOTORS*PHASES-1:0] low_sw,
    input wire logic                     hammer_coil,
    input wire logic                     board_fault_led
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire logic rd_hit = !io_request_n && !rd_n;
    wire logic wr_hit = !io_request_n && !wr_n;
    wire logic bad_code = (wdata[0] && wdata[2]) || (wdata[1] && wdata[3]);
    sequence s_wr(a);
        wr_hit && addr[6:0] == a;
    endsequence

    a_status_a_read: assert property (
        rd_hit && addr[6:0] == 7'h50 |=> rdata_oe && rdata == $past({3'h0, cover_open,
        paper_out, ribbon_out, left_margin, right_margin})) else $error("status A wrong");
    a_other_silent: assert property (
        !(rd_hit && addr[6:1] == 6'h28) |=> !rdata_oe && rdata == 8'h00)
        else $error("bus driven without status read");
    a_wheel_direct: assert property (
        s_wr(7'h58) ##0 (wdata[5:4] == 2'h0 && !bad_code && motor_power_ok
        && !board_fault_led) |-> ##2 phase_out[3:0] == $past(wdata[3:0], 2))
        else $error("wheel");
    a_fault_flag: assert property (
        s_wr(7'h58) ##0 bad_code |=> board_fault_led) else $error("fault not flagged");
    a_fault_drive_off: assert property (
        board_fault_led [*2] |-> (high_sw | low_sw) == '0 && !hammer_coil)
        else $error("drive left on under fault");
    a_coil_fire: assert property (
        s_wr(7'h5C) ##0 wdata[0] ##1 !(wr_hit && addr[6:0] == 7'h5C)
        ##1 !board_fault_led |-> hammer_coil) else $error("coil did not fire");
    a_hold_freeze: assert property (
        hold_out[0] [*2] |-> $stable(phase_out[3:0])) else $error("held motor moved");
    a_target_cut: assert property (
        cur_at_target[0] && !cur_below_low[0] |=> !high_sw[0]) else $error("no chop");
    a_switch_release: assert property (
        ((high_sw | low_sw) & ~$past(phase_out)) == '0) else $error("switch on, phase off");
endmodule // printer_port_ctrl_assertions

bind printer_port_ctrl printer_port_ctrl_assertions #(.MOTORS(MOTORS), .PHASES(PHASES))
    u_printer_port_ctrl_assertions (.*);
`default_nettype wire

// ### testbench/tb_top.sv
// Self-checking bench for the printer port block: host I/O, latches,
// sequencer, chopper, fault gating, reset. Winding model answers the switches.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        rd_n = 1'b1;
    logic        wr_n = 1'b1;
    logic        io_request_n = 1'b1;
    logic [4:0]  sensors = 5'h16;
    logic [7:0]  switches = 8'hA5;
    logic [3:0]  step_pulse = 4'h0;
    logic [15:0] cur_at_target, cur_below_low, phase_out, high_sw, low_sw;
    logic [7:0]  rdata, front_indicator_latch, service_readout;
    logic        rdata_oe, hammer_coil, board_fault_led;
    logic [3:0]  hold_out;
    logic [8:0]  got;
    int          n_fail = 0;
    int          compares = 0;
    int          cycles = 0;
    int          hi_cnt;
    // Status A is 16h and B is A5h for the sensor and switch levels above
    logic [7:0]  rd_addr [8] = '{8'h50, 8'h51, 8'h52, 8'h54, 8'h58, 8'h40, 8'hD0, 8'h70};
    logic [8:0]  rd_exp [8] = '{9'h116, 9'h1A5, 9'h000, 9'h000, 9'h000, 9'h000, 9'h116, 9'h000};
    logic [7:0]  mot_val [4] = '{8'h01, 8'h03, 8'h06, 8'h0C};
    logic [3:0]  seq_pat [8] = '{4'h1, 4'h3, 4'h2, 4'h6, 4'h4, 4'hC, 4'h8, 4'h9};
    wire logic [69:0] all_out = {hold_out, board_fault_led, service_readout, front_indicator_latch,
        hammer_coil, low_sw, high_sw, phase_out};

    printer_port_ctrl u_printer_port_ctrl (.clock(clock), .srst(srst), .addr(addr),
        .wdata(wdata), .rd_n(rd_n), .wr_n(wr_n), .io_request_n(io_request_n),
        .rdata(rdata), .rdata_oe(rdata_oe), .right_margin(sensors[0]),
        .left_margin(sensors[1]), .ribbon_out(sensors[2]), .paper_out(sensors[3]),
        .cover_open(sensors[4]), .top_of_page_sw(switches[0]), .paper_load_sw(switches[1]),
        .line_feed_down_sw(switches[2]), .line_feed_up_sw(switches[3]),
        .roll_down_sw(switches[4]), .roll_up_sw(switches[5]), .select_sw(switches[6]),
        .motor_power_ok(switches[7]), .step_pulse(step_pulse), .cur_at_target(cur_at_target),
        .cur_below_low(cur_below_low), .phase_out(phase_out), .hold_out(hold_out),
        .high_sw(high_sw), .low_sw(low_sw), .hammer_coil(hammer_coil),
        .front_indicator_latch(front_indicator_latch), .service_readout(service_readout),
        .board_fault_led(board_fault_led));
    winding_model u_winding_model (.clock(clock), .high_sw(high_sw), .low_sw(low_sw),
        .cur_at_target(cur_at_target), .cur_below_low(cur_below_low));

    // ----------------------------------------
    // Bus cycles and checking
    // ----------------------------------------
    always #4 clock = ~clock;
    task automatic chk(input logic [71:0] seen, input logic [71:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        io_request_n <= 1'b0;
        wr_n <= 1'b0;
        @(posedge clock);
        io_request_n <= 1'b1;
        wr_n <= 1'b1;
    endtask
    task automatic io_rd(input logic [7:0] a);
        @(posedge clock);
        addr <= a;
        io_request_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (2) @(posedge clock);
        io_request_n <= 1'b1;
        rd_n <= 1'b1;
        #1 got = {rdata_oe, rdata};
    endtask
    task automatic step0();
        @(posedge clock);
        step_pulse[0] <= 1'b1;  // Timer-paced step from the host
        repeat (2) @(posedge clock);
        step_pulse[0] <= 1'b0;
        tick(3);
    endtask
    task automatic stop_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        tick(1);
        chk(all_out, 70'h0);
        for (int k = 0; k < 8; k++) begin
            io_rd(rd_addr[k]);
            chk(got, rd_exp[k]);
        end
        io_wr(8'h54, 8'hA5);
        io_wr(8'h5F, 8'h3C);
        tick(2);
        chk({front_indicator_latch, service_readout}, 16'hA53C);
        for (int k = 0; k < 4; k++) begin
            io_wr(8'h58 + 8'(k), mot_val[k]);
        end
        tick(2);
        chk(phase_out, 16'hC631);
        tick(4);
        chk(low_sw, 16'hC631);
        hi_cnt = 0;
        repeat (60) begin
            tick(1);
            hi_cnt += (high_sw[0] === 1'b1) ? 1 : 0;
        end
        chk(hi_cnt inside {[5:40]}, 1'b1);
        @(posedge clock);
        switches[7] <= 1'b0;
        tick(4);
        chk({high_sw, low_sw}, 32'h0);
        io_rd(8'h51);
        chk(got, 9'h125);
        @(posedge clock);
        switches[7] <= 1'b1;
        io_wr(8'h58, 8'h00);
        tick(4);
        chk({phase_out[3:0], high_sw[3:0], low_sw}, 24'h0C630);
        io_wr(8'h58, 8'h05);
        io_wr(8'h5C, 8'h01);
        tick(3);
        chk({board_fault_led, hammer_coil, high_sw, low_sw}, {2'h2, 32'h0});
        io_wr(8'h58, 8'h00);  // Wheel parked before the coil fires
        io_wr(8'h5C, 8'h01);
        tick(2);
        chk({board_fault_led, hammer_coil}, 2'h1);
        io_wr(8'h5C, 8'h00);
        io_wr(8'h58, 8'h20);
        tick(3);
        chk(phase_out[3:0], seq_pat[0]);
        for (int k = 1; k <= 8; k++) begin
            step0();
            chk(phase_out[3:0], seq_pat[k % 8]);
        end
        io_wr(8'h58, 8'h60);
        step0();
        chk(phase_out[3:0], seq_pat[7]);
        io_wr(8'h58, 8'h30);
        step0();
        chk({hold_out[0], phase_out[3:0]}, {1'b1, seq_pat[7]});
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        tick(1);
        chk(all_out, 70'h0);
        stop_test();
    end
endmodule // tb_top
`default_nettype wire

// ### testbench/winding_model.sv
// Winding current model standing in for the four stepper motors.
// Assumes the switch outputs are registered on clock.
`timescale 1ns/1ps
`default_nettype none
module winding_model #(
    parameter int WINDINGS = 16
) (
    input  wire logic                clock,
    input  wire logic [WINDINGS-1:0] high_sw,
    input  wire logic [WINDINGS-1:0] low_sw,
    output logic      [WINDINGS-1:0] cur_at_target,
    output logic      [WINDINGS-1:0] cur_below_low
);
    // ----------------------------------------
    // Current per winding
    // ----------------------------------------
    logic [4:0] amp_q [WINDINGS] = '{default: 5'h00};
    always @(posedge clock) begin
        for (int w = 0; w < WINDINGS; w++) begin
            if (high_sw[w] && low_sw[w]) begin
                amp_q[w] <= amp_q[w] + 5'h03;  // Supply on: fast rise
            end else if (low_sw[w] && amp_q[w] != 5'h00) begin
                amp_q[w] <= amp_q[w] - 5'h01;  // Circulating current sags
            end else if (!low_sw[w]) begin
                amp_q[w] <= 5'h00;  // Both open: dumped into the supply
            end
        end
    end
    always_comb begin
        for (int w = 0; w < WINDINGS; w++) begin
            cur_at_target[w] = amp_q[w] >= 5'h0A;
            cur_below_low[w] = amp_q[w] <= 5'h06;
        end
    end
endmodule // winding_model
`default_nettype wire
